// *** rtl/pris_pkg.sv ***
/*
  Package for the processor reset and restart state block.
  Holds register offsets, reset values, field positions and the packed
  structs that carry the bus and pin groups.
  Assumes a 20 MHz clock and an AXI4-Lite register master.
*/
package pris_pkg;

  // Reset values loaded by a hard reset, and PRIS_FETCH_ENTRY loaded by a restart.
  localparam logic [31:0] PRIS_IP_RST       = 32'h0fff_fff6;
  localparam logic [31:0] PRIS_FETCH_ENTRY  = 32'h0fff_fff0;
  localparam logic [15:0] PRIS_CS_RST       = 16'hf000;
  localparam logic [31:0] PRIS_FLAGS_RST    = 32'h0000_0002;
  localparam logic [15:0] PRIS_FPCW_RST     = 16'h0040;
  localparam logic [15:0] PRIS_FPTW_RST     = 16'h5555;
  localparam logic [31:0] PRIS_CR0_RST      = 32'h6000_0010;
  localparam logic [31:0] PRIS_DR7_RST      = 32'h0000_0400;
  localparam logic [31:0] PRIS_DR6_RST      = 32'hffff_0ff0;
  localparam logic [15:0] PRIS_GDT_LIM_RST  = 16'h0fff;
  localparam logic [15:0] PRIS_IDT_LIM_RST  = 16'hffff;

  // Field positions of the cache-disable and no-writethrough bits.
  localparam int PRIS_CD_POS = 30;
  localparam int PRIS_NW_POS = 29;

  // Cycle counts of the initialisation sequence.
  localparam logic [7:0] PRIS_INIT_CYCLES = 8'h10;
  localparam logic [7:0] PRIS_BUILTIN_SELF_CHECK_CYCLES = 8'h20;

  // Register byte offsets on the bus.
  localparam logic [7:0] PRIS_CTRL_OFF    = 8'h00;
  localparam logic [7:0] PRIS_STATUS_OFF  = 8'h04;
  localparam logic [7:0] PRIS_IP_OFF      = 8'h08;
  localparam logic [7:0] PRIS_FLAGS_OFF   = 8'h0c;
  localparam logic [7:0] PRIS_ACC_OFF     = 8'h10;
  localparam logic [7:0] PRIS_DATA_OFF    = 8'h14;
  localparam logic [7:0] PRIS_CR0_OFF     = 8'h18;
  localparam logic [7:0] PRIS_DR7_OFF     = 8'h1c;
  localparam logic [7:0] PRIS_DR6_OFF     = 8'h20;
  localparam logic [7:0] PRIS_FPCW_OFF    = 8'h24;
  localparam logic [7:0] PRIS_FPTW_OFF    = 8'h28;
  localparam logic [7:0] PRIS_SEG_OFF     = 8'h2c;
  localparam logic [7:0] PRIS_GDT_OFF     = 8'h30;
  localparam logic [7:0] PRIS_IDT_OFF     = 8'h34;
  localparam logic [7:0] PRIS_TSC_LO_OFF  = 8'h38;
  localparam logic [7:0] PRIS_TSC_HI_OFF  = 8'h3c;
  localparam logic [7:0] PRIS_WRITE_HANDLING_CONTROL_REG_OFF    = 8'h40;
  localparam logic [7:0] PRIS_EVENT_OFF   = 8'h44;

  // Reset value of the software control register.
  localparam logic [31:0] PRIS_CTRL_RST = 32'h0000_0000;

  // AXI4-Lite response codes.
  localparam logic [1:0] PRIS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PRIS_RESP_SLVERR = 2'h2;

  // Sequencer states.
  typedef enum logic [2:0] {
    PRIS_ST_RESET,
    PRIS_ST_BUILTIN_SELF_CHECK,
    PRIS_ST_TRISTATE,
    PRIS_ST_INIT,
    PRIS_ST_RUN
  } pris_state_t;

  // Request signals of all five channels, master to slave.
  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } pris_axi_req_t;

  // Slave answers.
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pris_axi_rsp_t;

  // Output pins; all at fixed levels except page_cache_disable_out.
  typedef struct packed {
    logic address_strobe_n;
    logic address_strobe_copy_n;
    logic addr_parity_err_n;
    logic data_parity_err_n;
    logic cache_n;
    logic fp_error_n;
    logic hit_n;
    logic snoop_match_dirty_n;
    logic lock_n;
    logic smm_active_n;
    logic hold_ack;
    logic bus_request_out;
    logic data_code;
    logic mem_io;
    logic write_read;
    logic page_cache_disable_out;
    logic page_writethrough_out;
    logic split_cycle;
    logic core_voltage_detect;
  } pris_pins_t;

  // Output enables of the floating bus pins.
  typedef struct packed {
    logic addr_oe;
    logic addr_parity_oe;
    logic byte_enable_oe;
    logic data_oe;
    logic data_parity_oe;
    logic tdo_oe;
  } pris_oe_t;

endpackage

// *** rtl/pris_top.sv ***
/*
  Processor reset and restart state block.
  Holds the reset state of the architectural registers, drives the pin
  levels during reset, runs the self-check or test-mode choice and handles
  the soft restart with its latched events. Registers are reached over
  AXI4-Lite. Assumes rst_b, restart_n, purge_n and sys_mgmt_irq_n come from
  outside the clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module pris_top
  import pris_pkg::*;
#(
  parameter logic [31:0] SIGNATURE = 32'h0000_0a50, // Arbitrary identity value.
  parameter logic [3:0]  STEPPING  = 4'h1          // Arbitrary stepping value.
) (
  // Clock and reset.
  input  wire logic          clk,
  input  wire logic          rst_b,
  // Asynchronous request pins from system logic, then two synchronous inputs.
  input  wire logic          restart_n,
  input  wire logic          purge_n,
  input  wire logic          sys_mgmt_irq_n,
  input  wire logic          nmi_in,
  input  wire logic          insn_boundary,
  input  wire logic          builtin_self_check_fail,
  // Register bus.
  input  wire pris_axi_req_t axi_req,
  output var  pris_axi_rsp_t axi_rsp,
  // Output pins and enables.
  output var  pris_pins_t    pins,
  output var  pris_oe_t      pin_oe,
  // Status outputs.
  output var  logic          bus_enable,
  output var  logic          test_mode,
  output var  logic          purge_service,
  output var  logic          smi_service,
  output var  logic          nmi_pending
);

  // Reset release synchroniser; rst_s is the design reset.
  logic [1:0] rst_sync_reg;
  logic       rst_s;

  // Releases reset through two flip-flops.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_s = rst_sync_reg[1];

  // Two-stage synchronisers for the asynchronous pins.
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;

  // First stage feeds only the second stage.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= 4'hf;
      sync2_reg <= 4'hf;
    end else begin
      sync1_reg <= {restart_n, purge_n, sys_mgmt_irq_n, ~nmi_in};
      sync2_reg <= sync1_reg;
    end
  end

  // Named synchronised levels, active high.
  wire restart_lvl = ~sync2_reg[3];
  wire purge_lvl   = ~sync2_reg[2];
  wire smi_lvl     = ~sync2_reg[1];
  wire nmi_lvl     = ~sync2_reg[0];

  // Previous levels for edge detection.
  logic purge_prev_reg;
  logic smi_prev_reg;
  logic nmi_prev_reg;
  wire  purge_edge = purge_lvl & ~purge_prev_reg;
  wire  smi_edge   = smi_lvl & ~smi_prev_reg;
  wire  nmi_edge   = nmi_lvl & ~nmi_prev_reg;

  // Sequencer state and counter.
  pris_state_t state_reg;
  pris_state_t state_next;
  logic [7:0]  count_reg;
  logic        restart_req_reg;
  logic        soft_reg;

  // Architectural registers.
  logic [31:0] ip_reg;
  logic [31:0] flags_reg;
  logic [31:0] accumulator_reg;
  logic [31:0] data_reg;
  logic [31:0] control_reg_zero;
  logic [31:0] debug_control_reg;
  logic [31:0] debug_status_reg;
  logic [15:0] fp_control_reg;
  logic [15:0] fp_tag_reg;
  logic [63:0] time_stamp_counter;
  logic [63:0] write_handling_control_reg;
  logic [31:0] ctrl_reg;
  logic        purge_held_reg;
  logic        smi_held_reg;
  logic        nmi_held_reg;

  // Sequencer decode.
  wire cnt_done   = (count_reg == 8'h00);
  wire in_init    = (state_reg == PRIS_ST_INIT) | (state_reg == PRIS_ST_BUILTIN_SELF_CHECK);
  wire take_start = restart_req_reg & insn_boundary & (state_reg == PRIS_ST_RUN);

  // Held events are serviced only in normal running.
  wire svc_now = (state_reg == PRIS_ST_RUN) & ~take_start;

  // AXI4-Lite write path state: address and data taken in either order.
  logic        aw_have_reg;
  logic        w_have_reg;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  wire         wr_fire = aw_have_reg & w_have_reg & ~axi_rsp.bvalid;

  // Next-state logic of the reset and restart sequence.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      PRIS_ST_RESET:    state_next = purge_lvl ? PRIS_ST_TRISTATE : PRIS_ST_BUILTIN_SELF_CHECK;
      PRIS_ST_BUILTIN_SELF_CHECK:     state_next = cnt_done ? PRIS_ST_INIT : PRIS_ST_BUILTIN_SELF_CHECK;
      PRIS_ST_TRISTATE: state_next = PRIS_ST_TRISTATE;
      PRIS_ST_INIT:     state_next = cnt_done ? PRIS_ST_RUN : PRIS_ST_INIT;
      PRIS_ST_RUN:      state_next = take_start ? PRIS_ST_INIT : PRIS_ST_RUN;
    endcase
  end

  // Sequencer registers; the restart request is held until taken.
  always_ff @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
      state_reg       <= PRIS_ST_RESET;
      count_reg       <= PRIS_BUILTIN_SELF_CHECK_CYCLES;
      restart_req_reg <= 1'b0;
      soft_reg        <= 1'b0;
    end else begin
      state_reg       <= state_next;
      // A level still seen in the cycle of the take must not queue a second restart.
      restart_req_reg <= (restart_req_reg & ~take_start) | (restart_lvl & ~in_init & ~take_start);
      if (take_start) begin
        count_reg <= PRIS_INIT_CYCLES;
        soft_reg  <= 1'b1;
      end else if (state_reg == PRIS_ST_BUILTIN_SELF_CHECK && cnt_done) begin
        count_reg <= PRIS_INIT_CYCLES;
      end else if (!cnt_done) begin
        count_reg <= count_reg - 8'h01;
      end
      if (state_next == PRIS_ST_RUN) begin
        soft_reg <= 1'b0;
      end
    end
  end

  // Hard reset values, and restart entry that keeps the preserved state.
  always_ff @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
      ip_reg                     <= PRIS_IP_RST;
      flags_reg                  <= PRIS_FLAGS_RST;
      accumulator_reg            <= 32'h0000_0000;
      data_reg                   <= 32'h0000_0000;
      control_reg_zero           <= PRIS_CR0_RST;
      debug_control_reg          <= PRIS_DR7_RST;
      debug_status_reg           <= PRIS_DR6_RST;
      fp_control_reg             <= PRIS_FPCW_RST;
      fp_tag_reg                 <= PRIS_FPTW_RST;
      time_stamp_counter         <= 64'h0;
      write_handling_control_reg <= 64'h0;
    end else begin
      if (state_reg == PRIS_ST_BUILTIN_SELF_CHECK && cnt_done) begin
        accumulator_reg <= builtin_self_check_fail ? 32'h0000_0001 : 32'h0000_0000;
        data_reg        <= {SIGNATURE[31:4], STEPPING};
      end
      if (take_start) begin
        // Float, model-specific and cache bits are left untouched.
        ip_reg            <= PRIS_FETCH_ENTRY;
        flags_reg         <= PRIS_FLAGS_RST;
        accumulator_reg   <= 32'h0000_0000;
        data_reg          <= {SIGNATURE[31:4], STEPPING};
        control_reg_zero  <= (PRIS_CR0_RST & ~(32'h3 << PRIS_NW_POS))
                           | (control_reg_zero & (32'h3 << PRIS_NW_POS));
        debug_control_reg <= PRIS_DR7_RST;
        debug_status_reg  <= PRIS_DR6_RST;
      end else if (state_reg == PRIS_ST_RUN) begin
        time_stamp_counter <= time_stamp_counter + 64'h1;
      end
      if (wr_fire && wr_addr == PRIS_WRITE_HANDLING_CONTROL_REG_OFF) begin
        write_handling_control_reg[31:0] <= wr_data;
      end
    end
  end

  // Latched events; a new edge wins over the clear at service time.
  always_ff @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
      purge_prev_reg <= 1'b0;
      smi_prev_reg   <= 1'b0;
      nmi_prev_reg   <= 1'b0;
      purge_held_reg <= 1'b0;
      smi_held_reg   <= 1'b0;
      nmi_held_reg   <= 1'b0;
    end else begin
      purge_prev_reg <= purge_lvl;
      smi_prev_reg   <= smi_lvl;
      nmi_prev_reg   <= nmi_lvl;
      purge_held_reg <= purge_edge | (purge_held_reg & ~svc_now);
      smi_held_reg   <= smi_edge | (smi_held_reg & ~svc_now);
      nmi_held_reg   <= (nmi_edge | nmi_held_reg) & ~restart_lvl;
    end
  end

  // Pin levels: defined levels except in running, bus only after init.
  wire running = (state_reg == PRIS_ST_RUN);
  always_ff @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
      pins          <= '{default: 1'b1};
      pins.hold_ack <= 1'b0;
      pins.bus_request_out        <= 1'b0;
      pins.data_code              <= 1'b0;
      pins.mem_io                 <= 1'b0;
      pins.write_read             <= 1'b0;
      pins.page_cache_disable_out <= 1'b0;
      pins.page_writethrough_out  <= 1'b0;
      pins.split_cycle            <= 1'b0;
      pins.core_voltage_detect    <= 1'b0;
      pin_oe        <= '0;
      bus_enable    <= 1'b0;
      test_mode     <= 1'b0;
      purge_service <= 1'b0;
      smi_service   <= 1'b0;
      nmi_pending   <= 1'b0;
    end else begin
      pins.page_cache_disable_out <= running & control_reg_zero[PRIS_CD_POS];
      pin_oe        <= running ? '1 : '0;
      bus_enable    <= running & ctrl_reg[0];
      test_mode     <= (state_reg == PRIS_ST_TRISTATE);
      purge_service <= svc_now & purge_held_reg;
      smi_service   <= svc_now & smi_held_reg;
      nmi_pending   <= nmi_held_reg;
    end
  end

  // AXI4-Lite write path: address and data taken in either order.
  always_ff @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
      aw_have_reg     <= 1'b0;
      w_have_reg      <= 1'b0;
      wr_addr         <= 8'h00;
      wr_data         <= 32'h0;
      ctrl_reg        <= PRIS_CTRL_RST;
      axi_rsp.awready <= 1'b0;
      axi_rsp.wready  <= 1'b0;
      axi_rsp.bvalid  <= 1'b0;
      axi_rsp.bresp   <= PRIS_RESP_OKAY;
    end else begin
      axi_rsp.awready <= ~aw_have_reg & ~axi_rsp.awready & axi_req.awvalid;
      axi_rsp.wready  <= ~w_have_reg & ~axi_rsp.wready & axi_req.wvalid;
      if (axi_rsp.awready && axi_req.awvalid) begin
        aw_have_reg <= 1'b1;
        wr_addr     <= axi_req.awaddr;
      end
      if (axi_rsp.wready && axi_req.wvalid) begin
        w_have_reg <= 1'b1;
        wr_data    <= axi_req.wdata;
      end
      if (wr_fire) begin
        aw_have_reg    <= 1'b0;
        w_have_reg     <= 1'b0;
        axi_rsp.bvalid <= 1'b1;
        axi_rsp.bresp  <= (wr_addr == PRIS_CTRL_OFF || wr_addr == PRIS_WRITE_HANDLING_CONTROL_REG_OFF)
                          ? PRIS_RESP_OKAY : PRIS_RESP_SLVERR;
        if (wr_addr == PRIS_CTRL_OFF) begin
          ctrl_reg <= wr_data;
        end
      end else if (axi_req.bready) begin
        axi_rsp.bvalid <= 1'b0;
      end
    end
  end

  // Read decode of the register map.
  logic [31:0] rd_mux;
  logic        rd_ok;
  always_comb begin
    rd_ok  = 1'b1;
    unique case (axi_req.araddr)
      PRIS_CTRL_OFF:   rd_mux = ctrl_reg;
      PRIS_STATUS_OFF: rd_mux = {27'h0, state_reg, soft_reg, test_mode};
      PRIS_IP_OFF:     rd_mux = ip_reg;
      PRIS_FLAGS_OFF:  rd_mux = flags_reg;
      PRIS_ACC_OFF:    rd_mux = accumulator_reg;
      PRIS_DATA_OFF:   rd_mux = data_reg;
      PRIS_CR0_OFF:    rd_mux = control_reg_zero;
      PRIS_DR7_OFF:    rd_mux = debug_control_reg;
      PRIS_DR6_OFF:    rd_mux = debug_status_reg;
      PRIS_FPCW_OFF:   rd_mux = {16'h0, fp_control_reg};
      PRIS_FPTW_OFF:   rd_mux = {16'h0, fp_tag_reg};
      PRIS_SEG_OFF:    rd_mux = {16'h0, PRIS_CS_RST};
      PRIS_GDT_OFF:    rd_mux = {16'h0, PRIS_GDT_LIM_RST};
      PRIS_IDT_OFF:    rd_mux = {16'h0, PRIS_IDT_LIM_RST};
      PRIS_TSC_LO_OFF: rd_mux = time_stamp_counter[31:0];
      PRIS_TSC_HI_OFF: rd_mux = time_stamp_counter[63:32];
      PRIS_WRITE_HANDLING_CONTROL_REG_OFF:   rd_mux = write_handling_control_reg[31:0];
      PRIS_EVENT_OFF:  rd_mux = {29'h0, nmi_held_reg, smi_held_reg, purge_held_reg};
      default: begin
        rd_mux = 32'h0;
        rd_ok  = 1'b0;
      end
    endcase
  end

  // AXI4-Lite read path: one-cycle address accept, data the next cycle.
  always_ff @(posedge clk or negedge rst_s) begin
    if (!rst_s) begin
      axi_rsp.arready <= 1'b0;
      axi_rsp.rvalid  <= 1'b0;
      axi_rsp.rdata   <= 32'h0;
      axi_rsp.rresp   <= PRIS_RESP_OKAY;
    end else begin
      axi_rsp.arready <= axi_req.arvalid & ~axi_rsp.arready & ~axi_rsp.rvalid;
      if (axi_rsp.arready && axi_req.arvalid) begin
        axi_rsp.rvalid <= 1'b1;
        axi_rsp.rdata  <= rd_mux;
        axi_rsp.rresp  <= rd_ok ? PRIS_RESP_OKAY : PRIS_RESP_SLVERR;
      end else if (axi_req.rready) begin
        axi_rsp.rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// *** dv/pris_monitor.sv ***
/*
  Checker for pris_top: concurrent assertions over its ports only.
  Assumes it is bound onto pris_top and sees one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module pris_monitor
  import pris_pkg::*;
(
  // Clock, reset and requests.
  input wire logic          clk,
  input wire logic          rst_b,
  input wire logic          restart_n,
  input wire logic          nmi_in,
  // Bus, pins and status.
  input wire pris_axi_req_t axi_req,
  input wire pris_axi_rsp_t axi_rsp,
  input wire pris_pins_t    pins,
  input wire pris_oe_t      pin_oe,
  input wire logic          bus_enable,
  input wire logic          test_mode,
  input wire logic          nmi_pending
);
  default clocking mon_cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Cycles since reset release, held at its top so it never wraps.
  logic [7:0] up_cnt;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      up_cnt <= 8'h00;
    end else if (up_cnt != 8'hff) begin
      up_cnt <= up_cnt + 8'h01;
    end
  end

  float_at_release_a: assert property ($rose(rst_b) |-> (pin_oe == '0) [*2])
    else $error("bus pins driven at reset release");
  pins_high_a: assert property ($rose(rst_b) |-> pins[18:9] == 10'h3ff)
    else $error("strobe or check pins not high at reset");
  pins_low_a: assert property ($rose(rst_b) |-> pins[8:0] == 9'h000)
    else $error("cycle type pins not low at reset");
  bus_late_a: assert property (bus_enable |-> up_cnt > 8'h30)
    else $error("bus enabled before initialisation could end");
  test_float_a: assert property (test_mode |-> pin_oe == '0 && !bus_enable)
    else $error("pins driven in test mode");
  nmi_drop_a: assert property ((!restart_n) [*4] |=> !nmi_pending)
    else $error("held nmi survived restart");
  nmi_hold_a: assert property (restart_n [*3] ##0 $rose(nmi_in) ##1 restart_n [*5] |-> nmi_pending)
    else $error("nmi edge not held");
  read_answer_a: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read answer late");
  write_done_a: assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid)
    else $error("write response not released");
  unmapped_read_a: assert property (axi_req.arvalid && axi_rsp.arready && axi_req.araddr > 8'h44
    |=> axi_rsp.rresp == PRIS_RESP_SLVERR && axi_rsp.rdata == 32'h0)
    else $error("unmapped read not refused");

  // Main scenarios reached.
  cover property ($rose(test_mode));
  cover property ($rose(bus_enable));
  cover property (axi_rsp.bvalid && axi_req.bready && axi_rsp.bresp == PRIS_RESP_SLVERR);
endmodule

bind pris_top pris_monitor u_mon (
  .clk         (clk),
  .rst_b       (rst_b),
  .restart_n   (restart_n),
  .nmi_in      (nmi_in),
  .axi_req     (axi_req),
  .axi_rsp     (axi_rsp),
  .pins        (pins),
  .pin_oe      (pin_oe),
  .bus_enable  (bus_enable),
  .test_mode   (test_mode),
  .nmi_pending (nmi_pending)
);
`default_nettype wire

// *** dv/pris_syslogic.sv ***
/*
  Model of the system logic that drives reset, restart and event pins.
  Assumes the bench calls its tasks; all pins change after a rising edge.
*/
`timescale 1ns/10ps
`default_nettype none
module pris_syslogic (
  // Bus clock.
  input  wire logic clk,
  // Pins toward the device.
  output var  logic rst_b,
  output var  logic restart_n,
  output var  logic purge_n,
  output var  logic sys_mgmt_irq_n,
  output var  logic nmi_in
);
  // Reset is asserted from time zero, all other requests idle.
  initial begin
    rst_b = 1'b0;
    restart_n = 1'b1;
    purge_n = 1'b1;
    sys_mgmt_irq_n = 1'b1;
    nmi_in = 1'b0;
  end

  // Hard reset; the purge level at release picks self-check or test mode.
  task automatic hard_reset(input logic purge_lvl);
    @(posedge clk);
    rst_b <= 1'b0;
    purge_n <= purge_lvl;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    purge_n <= 1'b1;
  endtask

  // Restart held long enough for an asynchronous source, then events during it.
  task automatic soft_restart();
    restart_n <= 1'b0;
    repeat (4) @(posedge clk);
    restart_n <= 1'b1;
    repeat (4) @(posedge clk);
    sys_mgmt_irq_n <= 1'b0;
    purge_n <= 1'b0;
    repeat (3) @(posedge clk);
    sys_mgmt_irq_n <= 1'b1;
    purge_n <= 1'b1;
  endtask

  // One nmi pulse of three clocks.
  task automatic pulse_nmi();
    nmi_in <= 1'b1;
    repeat (3) @(posedge clk);
    nmi_in <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** dv/test_pris_top.sv ***
/*
  Self-checking bench for pris_top: register reads through AXI4-Lite,
  restart and reset scenarios. Assumes pris_syslogic drives the pins.
*/
`timescale 1ns/10ps
`default_nettype none
module test_pris_top;
  import pris_pkg::*;
  localparam logic [31:0] SIG  = 32'h0000_0a50; // Arbitrary identity value.
  localparam logic [3:0]  STEP = 4'h3;          // Arbitrary stepping value.
  typedef struct packed {logic [31:0] data; logic [31:0] mask; logic [1:0] resp;} pris_note_t;

  logic          clk = 1'b0;
  logic          rst_b, restart_n, purge_n, sys_mgmt_irq_n, nmi_in;
  logic          insn_boundary, builtin_self_check_fail;
  pris_axi_req_t axi_req;
  pris_axi_rsp_t axi_rsp;
  pris_pins_t    pins;
  pris_oe_t      pin_oe;
  logic          bus_enable, test_mode, purge_service, smi_service, nmi_pending;
  int            err_total = 0;
  int            check_count = 0;
  int            i;
  logic [31:0]   rd_last, wv;
  logic          seen_p, seen_s;
  pris_note_t    rd_q[$], wr_q[$];
  pris_note_t    rn, wn;

  always #25 clk = ~clk;

  pris_syslogic sys (.clk(clk), .rst_b(rst_b), .restart_n(restart_n), .purge_n(purge_n),
    .sys_mgmt_irq_n(sys_mgmt_irq_n), .nmi_in(nmi_in));
  pris_top #(.SIGNATURE(SIG), .STEPPING(STEP)) dut (.clk(clk), .rst_b(rst_b), .restart_n(restart_n),
    .purge_n(purge_n), .sys_mgmt_irq_n(sys_mgmt_irq_n), .nmi_in(nmi_in), .insn_boundary(insn_boundary),
    .builtin_self_check_fail(builtin_self_check_fail), .axi_req(axi_req), .axi_rsp(axi_rsp), .pins(pins), .pin_oe(pin_oe),
    .bus_enable(bus_enable), .test_mode(test_mode), .purge_service(purge_service),
    .smi_service(smi_service), .nmi_pending(nmi_pending));

  // Counts every comparison and reports a mismatch at once.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic conclude();
    if (err_total == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Read with a note of the expected word; waits are bounded.
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] r);
    @(posedge clk);
    rd_q.push_back(pris_note_t'{e, m, r});
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready <= 1'b1;
    for (i = 0; i < 60; i++) begin
      @(posedge clk);
      if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
      if (axi_rsp.rvalid) break;
    end
    rd_last = axi_rsp.rdata;
    axi_req.rready <= 1'b0;
    if (i == 60) begin
      err_total++;
      conclude();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    axi_rd(a, e, 32'hffff_ffff, PRIS_RESP_OKAY);
  endtask

  // Write with address and data offered together.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    wr_q.push_back(pris_note_t'{32'h0, 32'h0, r});
    axi_req.awaddr <= a;
    axi_req.awvalid <= 1'b1;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hf;
    axi_req.wvalid <= 1'b1;
    axi_req.bready <= 1'b1;
    for (i = 0; i < 60; i++) begin
      @(posedge clk);
      if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
      if (axi_rsp.bvalid) break;
    end
    axi_req.bready <= 1'b0;
    if (i == 60) begin
      err_total++;
      conclude();
    end
  endtask

  // Compares each bus answer with the oldest note.
  always @(posedge clk) begin
    if (axi_rsp.rvalid && axi_req.rready && rd_q.size() > 0) begin
      rn = rd_q.pop_front();
      check(axi_rsp.rdata & rn.mask, rn.data & rn.mask);
      check({30'h0, axi_rsp.rresp}, {30'h0, rn.resp});
    end
    if (axi_rsp.bvalid && axi_req.bready && wr_q.size() > 0) begin
      wn = wr_q.pop_front();
      check({30'h0, axi_rsp.bresp}, {30'h0, wn.resp});
    end
  end

  // Main sequence.
  initial begin
    void'($urandom(32'he4cc));
    axi_req = '0;
    insn_boundary = 1'b1;
    builtin_self_check_fail = 1'b0;
    sys.hard_reset(1'b1);
    repeat (60) @(posedge clk);
    rd(PRIS_IP_OFF, PRIS_IP_RST);
    rd(PRIS_SEG_OFF, {16'h0, PRIS_CS_RST});
    rd(PRIS_FLAGS_OFF, PRIS_FLAGS_RST);
    rd(PRIS_ACC_OFF, 32'h0);
    axi_rd(PRIS_DATA_OFF, {28'h0, STEP}, 32'hf, PRIS_RESP_OKAY);
    rd(PRIS_CR0_OFF, PRIS_CR0_RST);
    rd(PRIS_DR7_OFF, PRIS_DR7_RST);
    rd(PRIS_DR6_OFF, PRIS_DR6_RST);
    rd(PRIS_FPCW_OFF, {16'h0, PRIS_FPCW_RST});
    rd(PRIS_FPTW_OFF, {16'h0, PRIS_FPTW_RST});
    rd(PRIS_GDT_OFF, {16'h0, PRIS_GDT_LIM_RST});
    rd(PRIS_IDT_OFF, {16'h0, PRIS_IDT_LIM_RST});
    rd(PRIS_WRITE_HANDLING_CONTROL_REG_OFF, 32'h0);
    rd(PRIS_CTRL_OFF, PRIS_CTRL_RST);
    axi_rd(8'h48, 32'h0, 32'hffff_ffff, PRIS_RESP_SLVERR);
    wv = $urandom();
    axi_wr(PRIS_WRITE_HANDLING_CONTROL_REG_OFF, wv, PRIS_RESP_OKAY);
    axi_wr(PRIS_CR0_OFF, 32'h0, PRIS_RESP_SLVERR);
    axi_wr(8'h4c, 32'h1, PRIS_RESP_SLVERR);
    axi_wr(PRIS_CTRL_OFF, 32'h1, PRIS_RESP_OKAY);
    repeat (3) @(posedge clk);
    check({31'h0, bus_enable}, 32'h1);
    sys.pulse_nmi();
    repeat (4) @(posedge clk);
    check({31'h0, nmi_pending}, 32'h1);
    sys.soft_restart();
    check({31'h0, nmi_pending}, 32'h0);
    seen_p = 1'b0;
    seen_s = 1'b0;
    for (i = 0; i < 80 && !(seen_p && seen_s); i++) begin
      @(posedge clk);
      seen_p = seen_p | purge_service;
      seen_s = seen_s | smi_service;
    end
    check({31'h0, seen_p}, 32'h1);
    check({31'h0, seen_s}, 32'h1);
    rd(PRIS_IP_OFF, PRIS_FETCH_ENTRY);
    rd(PRIS_WRITE_HANDLING_CONTROL_REG_OFF, wv);
    rd(PRIS_CR0_OFF, PRIS_CR0_RST);
    rd(PRIS_FPTW_OFF, {16'h0, PRIS_FPTW_RST});
    insn_boundary <= 1'b0;
    sys.soft_restart();
    rd(PRIS_STATUS_OFF, {27'h0, PRIS_ST_RUN, 1'b0, 1'b0});
    insn_boundary <= 1'b1;
    repeat (3) @(posedge clk);
    rd(PRIS_STATUS_OFF, {27'h0, PRIS_ST_INIT, 1'b1, 1'b0});
    builtin_self_check_fail <= 1'b1;
    sys.hard_reset(1'b1);
    repeat (60) @(posedge clk);
    axi_rd(PRIS_ACC_OFF, 32'h0, 32'h0, PRIS_RESP_OKAY);
    check({31'h0, rd_last != 32'h0}, 32'h1);
    rd(PRIS_WRITE_HANDLING_CONTROL_REG_OFF, 32'h0);
    check({31'h0, bus_enable}, 32'h0);
    builtin_self_check_fail <= 1'b0;
    sys.hard_reset(1'b0);
    repeat (10) @(posedge clk);
    check({31'h0, test_mode}, 32'h1);
    check({26'h0, pin_oe}, 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
